// ===== rtl/brownout_reset_control.sv
`timescale 1ns/1ps
// How it works
// RULE_01: Enable field 01 lets software switch detection via bit 13.
// RULE_02: In software mode, bit set runs detection; bit clear disables it.
// RULE_03: Software enable bit reads 0 and is ignored outside software mode.
// RULE_04: Trip level always comes from the threshold configuration field.
// RULE_05: While enabled, brown-out and power-on events set the brown-out flag.
// RULE_06: Deep Sleep exit sets both power-on and brown-out flags.
// RULE_07: Software should clear both flags right after power-on reset.
// RULE_08: Enable field 10 keeps hardware control but disables in Sleep.
// RULE_09: In that mode, detection re-enables on leaving Sleep.
// RULE_10: Reset is held while supply is below threshold, released above.
// RULE_11: Power-up timer starts above threshold; new dip restarts it.
// RULE_12: Power-up timer enable is independent of brown-out enable.
// RULE_13: Detector output is synchronised and gated by effective enable.
module brownout_reset_control
  import brownout_pkg::*;
#(
  parameter int unsigned POWERUP_COUNT = POWERUP_CYCLES
) (
  input  wire logic                        MCLK_I,
  input  wire logic                        NRST_I,
  input  wire poweron_config_word_t        CFG_I,
  input  wire logic                        BELOW_THRESH_I,
  input  wire logic                        POR_EVENT_I,
  input  wire logic                        SLEEP_I,
  input  wire logic                        DEEP_SLEEP_EXIT_I,
  input  wire logic                        SW_ENABLE_WR_I,
  input  wire logic                        SW_ENABLE_DATA_I,
  input  wire flag_clear_t                 FLAG_CLR_I,
  output logic [THRESH_SEL_W-1:0]          THRESHOLD_SEL_O,
  output logic                             DETECT_EN_O,
  output logic                             BOR_RESET_O,
  output logic                             SYS_RESET_O,
  output reset_status_t                    STATUS_O,
  output logic [RESET_CTRL_W-1:0]          RESET_CTRL_O
);

  typedef enum logic [1:0] {
    ST_RUN   = 2'h0,
    ST_BROWN = 2'h1,
    ST_POWERUP_TIMER  = 2'h2
  } rst_state_t;

  logic                  rst_sync1_reg;
  logic                  rst_sync2_reg;
  logic                  rst_n;
  logic                  below_s1_reg;
  logic                  below_s2_reg;
  logic                  sw_en_reg;
  logic                  sw_en_next;
  logic                  bor_flag_reg;
  logic                  bor_flag_next;
  logic                  por_flag_reg;
  logic                  por_flag_next;
  rst_state_t            state_reg;
  rst_state_t            state_next;
  logic [POWERUP_TIMER_CNT_W-1:0] cnt_reg;
  logic [POWERUP_TIMER_CNT_W-1:0] cnt_next;
  wire                   mode_sw;
  wire                   mode_sleep;
  wire                   mode_hw;
  wire                   detect_en;
  wire                   brown_event;
  wire                   powerup_timer_done;
  wire                   sw_term;
  wire                   sleep_term;
  wire                   timer_en;
  wire                   bor_set;
  wire                   por_set;
  wire                   in_brown;
  wire                   in_run;

  localparam logic [POWERUP_TIMER_CNT_W-1:0] POWERUP_TIMER_LAST =
    POWERUP_TIMER_CNT_W'(POWERUP_COUNT - 1);

  // One compare for each of the three enabling configuration codes keeps the decode in one place.
  function automatic logic mode_is(input bor_mode_t cfg,
                                   input bor_mode_t want);
    return cfg == want;
  endfunction

  // A status flag holds until software clears it, and a hardware set in
  // the same cycle as the clear wins, so no event is ever lost.
  function automatic logic sticky_next(input logic set,
                                       input logic cur,
                                       input logic clr);
    return set || (cur && !clr);
  endfunction

  // Reset release through two flops; assertion stays asynchronous.
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign rst_n = rst_sync2_reg;

  assign mode_sw    = mode_is(CFG_I.enable_cfg, BOR_MODE_SW);    // RULE_01
  assign mode_sleep = mode_is(CFG_I.enable_cfg, BOR_MODE_SLEEP);
  assign mode_hw    = mode_is(CFG_I.enable_cfg, BOR_MODE_HW);
  assign timer_en   = CFG_I.powerup_timer_en;                    // RULE_12

  // Sleep mode gates only the sleep-disable configuration.
  assign sw_term    = mode_sw && sw_en_reg;                      // RULE_02
  assign sleep_term = mode_sleep && !SLEEP_I;            // RULE_08 RULE_09
  assign detect_en  = sw_term || sleep_term || mode_hw;          // RULE_10

  assign THRESHOLD_SEL_O = CFG_I.threshold_sel;        // RULE_04
  assign DETECT_EN_O     = detect_en;

  // Only the second synchroniser flop is looked at.
  assign brown_event = below_s2_reg && detect_en;      // RULE_13

  // The detector output is not tied to the clock, so it is never used raw.
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      below_s1_reg <= 1'b0;
      below_s2_reg <= 1'b0;
    end else begin
      below_s1_reg <= BELOW_THRESH_I;
      below_s2_reg <= below_s1_reg;                    // RULE_13
    end
  end

  // Writes outside software mode are dropped so the bit reads back 0.
  assign sw_en_next = !mode_sw ? 1'b0 :                // RULE_03
                      SW_ENABLE_WR_I ? SW_ENABLE_DATA_I : sw_en_reg;

  assign bor_set = brown_event || (detect_en && POR_EVENT_I)  // RULE_05
                 || DEEP_SLEEP_EXIT_I;                        // RULE_06
  assign por_set = POR_EVENT_I || DEEP_SLEEP_EXIT_I;          // RULE_06

  assign bor_flag_next = sticky_next(bor_set, bor_flag_reg,
                                     FLAG_CLR_I.clr_bor);
  assign por_flag_next = sticky_next(por_set, por_flag_reg,
                                     FLAG_CLR_I.clr_por);

  assign powerup_timer_done = (cnt_reg == POWERUP_TIMER_LAST);

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    unique case (state_reg)
      ST_RUN: begin
        if (brown_event) begin
          state_next = ST_BROWN;                       // RULE_10
        end
      end
      ST_BROWN: begin
        // Clearing here gives every recovery the full power-up delay.
        cnt_next = '0;
        if (!brown_event) begin
          // Timer enable is its own field, not implied by detection.
          state_next = timer_en ? ST_POWERUP_TIMER : ST_RUN;    // RULE_12
        end
      end
      ST_POWERUP_TIMER: begin
        cnt_next = cnt_reg + POWERUP_TIMER_CNT_W'(1);
        if (brown_event) begin
          state_next = ST_BROWN;                       // RULE_11
        end else if (powerup_timer_done) begin
          state_next = ST_RUN;                         // RULE_11
        end
      end
      default: begin
        state_next = ST_BROWN;
      end
    endcase
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      sw_en_reg <= SW_ENABLE_RST;
    end else begin
      sw_en_reg <= sw_en_next;                         // RULE_01
    end
  end

  // Flags start set so software can tell a power-on from a later dip.
  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      bor_flag_reg <= FLAG_RST;
      por_flag_reg <= FLAG_RST;
    end else begin
      bor_flag_reg <= bor_flag_next;
      por_flag_reg <= por_flag_next;
    end
  end

  always_ff @(posedge MCLK_I or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= ST_RUN;
      cnt_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
    end
  end

  assign in_brown = (state_reg == ST_BROWN);
  assign in_run   = (state_reg == ST_RUN);

  assign BOR_RESET_O = in_brown;                       // RULE_10
  assign SYS_RESET_O = !in_run;                        // RULE_11

  assign STATUS_O.sw_enable = sw_en_reg;
  assign STATUS_O.bor_flag  = bor_flag_reg;
  assign STATUS_O.por_flag  = por_flag_reg;

  // Unused bit positions read as zero.
  always_comb begin
    RESET_CTRL_O                = '0;
    RESET_CTRL_O[SW_ENABLE_BIT] = sw_en_reg;           // RULE_03
    RESET_CTRL_O[BOR_FLAG_BIT]  = bor_flag_reg;
    RESET_CTRL_O[POR_FLAG_BIT]  = por_flag_reg;
  end

endmodule

// ===== rtl/brownout_pkg.sv
package brownout_pkg;

  // Brown-out enable configuration field encodings.
  typedef enum logic [1:0] {
    BOR_MODE_OFF   = 2'h0,
    BOR_MODE_SW    = 2'h1,
    BOR_MODE_SLEEP = 2'h2,
    BOR_MODE_HW    = 2'h3
  } bor_mode_t;

  localparam int unsigned THRESH_SEL_W = 2;
  localparam int unsigned RESET_CTRL_W = 16;

  // Bit positions inside the reset control register.
  localparam int unsigned POR_FLAG_BIT  = 0;
  localparam int unsigned BOR_FLAG_BIT  = 1;
  localparam int unsigned SW_ENABLE_BIT = 13;

  // Reset values of the software enable bit and the two status flags.
  localparam logic SW_ENABLE_RST = 1'b0;
  localparam logic FLAG_RST      = 1'b1;

  // Power-up delay, in microseconds, and the clock rate.
  localparam int unsigned POWERUP_DELAY_US = 64;
  localparam int unsigned CLK_MHZ          = 100;
  localparam int unsigned POWERUP_CYCLES   = POWERUP_DELAY_US * CLK_MHZ;
  localparam int unsigned POWERUP_TIMER_CNT_W       = 24;

  // Configuration word fields taken from non-volatile storage.
  typedef struct packed {
    bor_mode_t                 enable_cfg;
    logic [THRESH_SEL_W-1:0]   threshold_sel;
    logic                      powerup_timer_en;
  } poweron_config_word_t;

  // Status flag block presented to software.
  typedef struct packed {
    logic sw_enable;
    logic bor_flag;
    logic por_flag;
  } reset_status_t;

  // Software clear request: one bit per status flag.
  typedef struct packed {
    logic clr_bor;
    logic clr_por;
  } flag_clear_t;

endpackage

// ===== verification/supply_detector_model.sv
`timescale 1ns/1ps
module supply_detector_model (
  input  wire logic [7:0] supply_i,
  input  wire logic [1:0] threshold_sel_i,
  output logic            below_o
);
  // Trip levels are plain test values, one for each selector code.
  localparam logic [7:0] TRIP [4] = '{8'h20, 8'h80, 8'hA0, 8'hC0};
  assign below_o = supply_i < TRIP[threshold_sel_i];
endmodule

// ===== verification/brownout_reset_control_assertions.sv
`timescale 1ns/1ps
module brownout_checker
  import brownout_pkg::*;
#(
  parameter int unsigned POWERUP_COUNT = POWERUP_CYCLES
) (
  input  wire logic                    MCLK_I,
  input  wire logic                    NRST_I,
  input  wire logic                    BELOW_THRESH_I,
  input  wire logic                    POR_EVENT_I,
  input  wire logic                    SLEEP_I,
  input  wire logic                    DEEP_SLEEP_EXIT_I,
  input  wire logic                    SW_ENABLE_WR_I,
  input  wire logic                    SW_ENABLE_DATA_I,
  input  wire poweron_config_word_t    CFG_I,
  input  wire logic [THRESH_SEL_W-1:0] THRESHOLD_SEL_O,
  input  wire logic                    DETECT_EN_O,
  input  wire logic                    BOR_RESET_O,
  input  wire logic                    SYS_RESET_O,
  input  wire reset_status_t           STATUS_O
);
  localparam int HOLD  = POWERUP_COUNT;
  localparam int HOLD1 = POWERUP_COUNT + 1;
  logic [1:0] rel_q;
  // Follow the two-flop reset release of the design, so nothing is
  // judged while its registers still sit at their reset values.
  always_ff @(posedge MCLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rel_q <= 2'h0;
    end else begin
      rel_q <= {rel_q[0], 1'b1};
    end
  end
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!rel_q[1]);
  sequence s_dip;
    $rose(BELOW_THRESH_I) && DETECT_EN_O ##1
      (BELOW_THRESH_I && DETECT_EN_O) [*2];
  endsequence
  sequence s_rise;
    $fell(BELOW_THRESH_I) && BOR_RESET_O ##1 !BELOW_THRESH_I [*2];
  endsequence
  a_thresh_copy: assert property (
    THRESHOLD_SEL_O == CFG_I.threshold_sel)
    else $error("threshold select differs from config");
  a_enable_decode: assert property (DETECT_EN_O == (
    CFG_I.enable_cfg == BOR_MODE_HW ||
    (CFG_I.enable_cfg == BOR_MODE_SLEEP && !SLEEP_I) ||
    (CFG_I.enable_cfg == BOR_MODE_SW && STATUS_O.sw_enable)))
    else $error("effective enable wrong");
  a_sw_write: assert property (SW_ENABLE_WR_I && CFG_I.enable_cfg ==
    BOR_MODE_SW |=> STATUS_O.sw_enable == $past(SW_ENABLE_DATA_I))
    else $error("software enable write lost");
  a_sw_reads_zero: assert property (CFG_I.enable_cfg != BOR_MODE_SW
    ##1 CFG_I.enable_cfg != BOR_MODE_SW |-> !STATUS_O.sw_enable)
    else $error("software enable visible outside its mode");
  a_bor_entry: assert property (s_dip |=>
    BOR_RESET_O && SYS_RESET_O && STATUS_O.bor_flag)
    else $error("brown-out not entered on time");
  a_bor_release: assert property (s_rise |=> !BOR_RESET_O)
    else $error("brown-out not released on time");
  a_timer_span: assert property ($fell(SYS_RESET_O) &&
    CFG_I.powerup_timer_en |-> !$past(BOR_RESET_O, HOLD) &&
    $past(BOR_RESET_O, HOLD1)) else $error("power-up delay wrong");
  a_timer_off: assert property ($fell(BOR_RESET_O) &&
    !CFG_I.powerup_timer_en |-> !SYS_RESET_O)
    else $error("reset held without power-up timer");
  a_por_sets_flags: assert property (POR_EVENT_I && DETECT_EN_O
    |=> STATUS_O.bor_flag && STATUS_O.por_flag) else $error("por flags");
  a_deep_exit: assert property (DEEP_SLEEP_EXIT_I
    |=> STATUS_O.bor_flag && STATUS_O.por_flag) else $error("wake flags");
endmodule
bind brownout_reset_control brownout_checker #(
  .POWERUP_COUNT(POWERUP_COUNT)) chk (.MCLK_I(MCLK_I), .NRST_I(NRST_I),
  .BELOW_THRESH_I(BELOW_THRESH_I), .POR_EVENT_I(POR_EVENT_I),
  .SLEEP_I(SLEEP_I), .DEEP_SLEEP_EXIT_I(DEEP_SLEEP_EXIT_I),
  .SW_ENABLE_WR_I(SW_ENABLE_WR_I), .SW_ENABLE_DATA_I(SW_ENABLE_DATA_I),
  .CFG_I(CFG_I), .THRESHOLD_SEL_O(THRESHOLD_SEL_O), .STATUS_O(STATUS_O),
  .DETECT_EN_O(DETECT_EN_O), .BOR_RESET_O(BOR_RESET_O),
  .SYS_RESET_O(SYS_RESET_O));

// ===== verification/brownout_reset_control_tb.sv
`timescale 1ns/1ps
module brownout_reset_control_tb
  import brownout_pkg::*;
;
  `define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin \
    num_errors++; $display("[FAIL] %0t got %h exp %h", $time, a, b); end end
  logic clk = 0, nrst = 0, por = 0, slp = 0, dse = 0, wr = 0, wd = 0;
  logic below, den, borr, sysr;
  logic [7:0] supply = 8'hFF;
  logic [1:0] thr;
  logic [RESET_CTRL_W-1:0] rc;
  poweron_config_word_t cfg = '{BOR_MODE_HW, 2'h1, 1'b1};
  flag_clear_t clr = '0;
  reset_status_t st;
  int num_errors = 0, tests_run = 0;
  supply_detector_model model (.supply_i(supply), .threshold_sel_i(thr),
    .below_o(below));
  // A short power-up count keeps the run brief.
  brownout_reset_control #(.POWERUP_COUNT(8)) dut (.MCLK_I(clk),
    .NRST_I(nrst), .CFG_I(cfg), .BELOW_THRESH_I(below), .POR_EVENT_I(por),
    .SLEEP_I(slp), .DEEP_SLEEP_EXIT_I(dse), .SW_ENABLE_WR_I(wr),
    .SW_ENABLE_DATA_I(wd), .FLAG_CLR_I(clr), .THRESHOLD_SEL_O(thr),
    .DETECT_EN_O(den), .BOR_RESET_O(borr), .SYS_RESET_O(sysr),
    .STATUS_O(st), .RESET_CTRL_O(rc));
  initial forever #5 clk = ~clk;
  task automatic step(int n = 1);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic final_report();
    $display("errors %0d checks %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic flags_test();
    clr = '{1'b1, 1'b1}; step(); clr = '0;
    `CHK(rc, 16'h0000)
    dse = 1; step(); dse = 0;
    `CHK(rc, 16'h0003)
    `CHK(st, 3'h3)
    clr = '{1'b1, 1'b1}; step(); clr = '0; por = 1; step(); por = 0;
    `CHK(rc, 16'h0003)
    dse = 1; clr = '{1'b1, 1'b1}; step(); dse = 0;
    `CHK(st, 3'h3)
    step(); clr = '0;
    $display("flags test done");
  endtask
  task automatic hw_dip_test();
    supply = 8'h40; step(3);
    `CHK(borr, 1'b1)
    `CHK(rc, 16'h0002)
    `CHK(thr, 2'h1)
    supply = 8'hFF; step(3);
    `CHK(borr, 1'b0)
    step(3); supply = 8'h40; step(3);
    `CHK(borr, 1'b1)
    supply = 8'hFF; step(10);
    `CHK(sysr, 1'b1)
    step();
    `CHK(sysr, 1'b0)
    // Keep the timer enabled until the edge that sees its reset end.
    step();
    cfg.powerup_timer_en = 0; supply = 8'h40; step(4); supply = 8'hFF; step(3);
    `CHK(sysr, 1'b0)
    cfg.threshold_sel = 2'h0; supply = 8'h40; step(4);
    `CHK(thr, 2'h0)
    `CHK(borr, 1'b0)
    cfg.threshold_sel = 2'h1; supply = 8'hFF; step(3);
    $display("hardware dip test done");
  endtask
  task automatic sw_test();
    cfg.enable_cfg = BOR_MODE_SW; wr = 1; step(); wr = 0;
    `CHK(den, 1'b0)
    supply = 8'h40; step(4);
    `CHK(borr, 1'b0)
    supply = 8'hFF; step(3); wd = 1; wr = 1; step(); wr = 0;
    `CHK(rc[SW_ENABLE_BIT], 1'b1)
    `CHK(den, 1'b1)
    `CHK(st.sw_enable, 1'b1)
    cfg.enable_cfg = BOR_MODE_HW; step(2); wr = 1; step(); wr = 0;
    `CHK(rc[SW_ENABLE_BIT], 1'b0)
    $display("software enable test done");
  endtask
  task automatic sleep_test();
    cfg.enable_cfg = BOR_MODE_SLEEP; slp = 1; supply = 8'h40; step(4);
    `CHK(borr, 1'b0)
    supply = 8'hFF; step(3); slp = 0; step();
    `CHK(den, 1'b1)
    cfg.enable_cfg = BOR_MODE_OFF; step();
    `CHK(den, 1'b0)
    $display("sleep test done");
  endtask
  // The whole sequence needs well under two hundred cycles.
  initial begin
    #20000;
    num_errors++;
    final_report();
  end
  initial begin
    step(12); nrst = 1; step(3);
    flags_test();
    hw_dip_test();
    sw_test();
    sleep_test();
    final_report();
  end
endmodule
